/* File: rtl/flash_device_end.sv */
// Purpose: Flash command decoder, embedded program/erase engine and status.
// Assumes: Host issues one bus cycle per clock; clk_en freezes everything.
// Notes:   Array is a scaled model indexed by bank/sector bits and low bits.
//
// Operation
// - Status reads while busy are asynchronous only
// - Host compares two status reads before deciding
// - Busy shows inverted data, then true data
// - Toggle bits flip per read, steady when done
// - Unlock cycles ignore address bits sixteen upward
// - Erase preprograms region to zero first
// - Program accepted as two or four cycles
// - Write buffer holds up to 32 words
// - Other banks readable while one bank busy
// - No wait between reads and writes
// - Protected program toggles 20 us, no change
// - Sector protection toggles 20 us typical
// - Host gives sector address in last cycle
`timescale 1ns/100ps
module flash_device_end
  import flash_seq_pkg::*;
#(
  parameter int unsigned PROG_CYCLES  = PROG_US * CLK_MHZ,
  parameter int unsigned BUF_CYCLES   = BUF_PROG_US * CLK_MHZ,
  parameter int unsigned ERASE_CYCLES = ERASE_US * CLK_MHZ
) (
  input  wire logic          ref_clk,
  input  wire logic          reset,
  input  wire logic          clk_en,
  flash_link_if.device       link,
  output logic               busy,
  output logic [BANK_W-1:0]  busy_bank,
  output logic [NUM_SECT-1:0] protect_map
);
  typedef enum logic [3:0] {
    CMD_IDLE     = 4'h0,
    CMD_UNLOCK1  = 4'h1,
    CMD_UNLOCKED = 4'h2,
    CMD_PROG_DAT = 4'h3,
    CMD_ERASE_U0 = 4'h4,
    CMD_ERASE_U1 = 4'h5,
    CMD_ERASE_U2 = 4'h6,
    CMD_BUF_CNT  = 4'h7,
    CMD_BUF_DAT  = 4'h8,
    CMD_BUF_CONF = 4'h9
  } cmd_state_type;

  typedef enum logic [2:0] {
    ENG_IDLE     = 3'h0,
    ENG_PROG     = 3'h1,
    ENG_BUF_WAIT = 3'h2,
    ENG_BUF_APPL = 3'h3,
    ENG_PREPROG  = 3'h4,
    ENG_ERS_WAIT = 3'h5,
    ENG_ERASE    = 3'h6,
    ENG_TOGGLE   = 3'h7
  } eng_state_type;

  logic [DATA_W-1:0] mem_q      [2**MEM_AW];
  logic [MEM_AW-1:0] buf_idx_q  [BUF_WORDS];
  logic [DATA_W-1:0] buf_data_q [BUF_WORDS];

  cmd_state_type       cmd_q, cmd_d;
  eng_state_type       eng_q, eng_d;
  logic [ADDR_W-1:0]   tgt_q, tgt_d;
  logic [DATA_W-1:0]   val_q, val_d;
  logic [TIMER_W-1:0]  timer_q, timer_d;
  logic [MEM_AW-1:0]   walk_q, walk_d;
  logic                chip_q, chip_d;
  logic                prot_op_q, prot_op_d;
  logic                tog_q, tog_d;
  logic [BUF_AW-1:0]   cnt_q, cnt_d;
  logic [BUF_AW-1:0]   fill_q, fill_d;
  logic [NUM_SECT-1:0] prot_q, prot_d;
  logic [DATA_W-1:0]   rdata_q, rdata_d;
  logic                rvalid_q, rvalid_d;
  logic                mem_we, buf_we;
  logic [MEM_AW-1:0]   mem_wi;
  logic [DATA_W-1:0]   mem_wd;
  logic [BUF_AW-1:0]   buf_wi;

  function automatic logic [MEM_AW-1:0] mem_idx(input logic [ADDR_W-1:0] a);
    return {a[ADDR_W-1 -: HI_W], a[LO_W-1:0]};
  endfunction : mem_idx

  function automatic logic [HI_W-1:0] sect_of(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1 -: HI_W];
  endfunction : sect_of

  logic               wr_ok, bank_hit, in_region, walk_last;
  logic [UNLOCK_W-1:0] lo;
  logic [DATA_W-1:0]   status_word;

  always_comb begin
    cmd_d     = cmd_q;
    eng_d     = eng_q;
    tgt_d     = tgt_q;
    val_d     = val_q;
    timer_d   = timer_q;
    walk_d    = walk_q;
    chip_d    = chip_q;
    prot_op_d = prot_op_q;
    tog_d     = tog_q;
    cnt_d     = cnt_q;
    fill_d    = fill_q;
    prot_d    = prot_q;
    rdata_d   = rdata_q;
    rvalid_d  = 1'b0;
    mem_we    = 1'b0;
    mem_wi    = '0;
    mem_wd    = '0;
    buf_we    = 1'b0;
    buf_wi    = fill_q;
    lo        = link.addr[UNLOCK_W-1:0];
    wr_ok     = link.wr_en && (eng_q == ENG_IDLE);
    walk_last = (walk_q == {MEM_AW{1'b1}});
    in_region = (chip_q || walk_q[MEM_AW-1 -: HI_W] == sect_of(tgt_q))
                && !prot_q[walk_q[MEM_AW-1 -: HI_W]];
    bank_hit  = chip_q || (link.addr[ADDR_W-1 -: BANK_W] == tgt_q[ADDR_W-1 -: BANK_W]);
    status_word              = '0;
    status_word[POLL_BIT]    = ~val_q[POLL_BIT];
    status_word[TOGGLE_BIT]  = tog_q;
    status_word[TOGGLE2_BIT] = tog_q;

    if (wr_ok) begin
      unique case (cmd_q)
        CMD_IDLE: begin
          if (link.wdata == CMD_PROG) cmd_d = CMD_PROG_DAT;
          else if (lo == UNLOCK_A1 && link.wdata == UNLOCK_D1) cmd_d = CMD_UNLOCK1;
        end
        CMD_UNLOCK1: begin
          cmd_d = (lo == UNLOCK_A2 && link.wdata == UNLOCK_D2) ? CMD_UNLOCKED : CMD_IDLE;
        end
        CMD_UNLOCKED: begin
          cmd_d = CMD_IDLE;
          tgt_d = link.addr;
          if (link.wdata == CMD_PROG) cmd_d = CMD_PROG_DAT;
          else if (link.wdata == CMD_ERASE_SETUP) cmd_d = CMD_ERASE_U0;
          else if (link.wdata == CMD_BUF_LOAD) cmd_d = CMD_BUF_CNT;
          else if (link.wdata == CMD_PROTECT) begin
            eng_d     = ENG_TOGGLE;
            prot_op_d = 1'b1;
            chip_d    = 1'b0;
            val_d     = ERASED_WORD;
            timer_d   = TOGGLE_PROT_CYC;
          end
        end
        CMD_PROG_DAT: begin
          cmd_d     = CMD_IDLE;
          tgt_d     = link.addr;
          val_d     = link.wdata;
          chip_d    = 1'b0;
          prot_op_d = 1'b0;
          if (prot_q[sect_of(link.addr)]) begin
            eng_d   = ENG_TOGGLE;
            timer_d = TOGGLE_PROT_CYC;
          end else begin
            eng_d   = ENG_PROG;
            timer_d = TIMER_W'(PROG_CYCLES);
          end
        end
        CMD_ERASE_U0: begin
          cmd_d = (lo == UNLOCK_A1 && link.wdata == UNLOCK_D1) ? CMD_ERASE_U1 : CMD_IDLE;
        end
        CMD_ERASE_U1: begin
          cmd_d = (lo == UNLOCK_A2 && link.wdata == UNLOCK_D2) ? CMD_ERASE_U2 : CMD_IDLE;
        end
        CMD_ERASE_U2: begin
          cmd_d     = CMD_IDLE;
          tgt_d     = link.addr;
          val_d     = ERASED_WORD;
          prot_op_d = 1'b0;
          walk_d    = '0;
          if (link.wdata == CMD_CHIP_ERASE) begin
            chip_d = 1'b1;
            eng_d  = ENG_PREPROG;
          end else if (link.wdata == CMD_SECT_ERASE) begin
            chip_d = 1'b0;
            if (prot_q[sect_of(link.addr)]) begin
              eng_d   = ENG_TOGGLE;
              timer_d = TOGGLE_PROT_CYC;
            end else begin
              eng_d = ENG_PREPROG;
            end
          end
        end
        CMD_BUF_CNT: begin
          // Count field keeps its low BUF_AW bits: 32 words at most, larger counts wrap
          cnt_d  = link.wdata[BUF_AW-1:0];
          fill_d = '0;
          cmd_d  = CMD_BUF_DAT;
        end
        CMD_BUF_DAT: begin
          buf_we = 1'b1;
          fill_d = fill_q + 1'b1;
          if (fill_q == cnt_q) cmd_d = CMD_BUF_CONF;
        end
        CMD_BUF_CONF: begin
          cmd_d     = CMD_IDLE;
          chip_d    = 1'b0;
          prot_op_d = 1'b0;
          val_d     = buf_data_q[cnt_q];
          if (link.wdata == CMD_BUF_CONFIRM) begin
            eng_d   = prot_q[sect_of(tgt_q)] ? ENG_TOGGLE : ENG_BUF_WAIT;
            timer_d = prot_q[sect_of(tgt_q)] ? TOGGLE_PROT_CYC : TIMER_W'(BUF_CYCLES);
          end
        end
        default: cmd_d = CMD_IDLE;
      endcase
    end

    unique case (eng_q)
      ENG_IDLE: ;
      ENG_PROG: begin
        timer_d = timer_q - 1'b1;
        if (timer_q <= 1) begin
          mem_we = 1'b1;
          mem_wi = mem_idx(tgt_q);
          mem_wd = mem_q[mem_idx(tgt_q)] & val_q;
          eng_d  = ENG_IDLE;
        end
      end
      ENG_BUF_WAIT: begin
        timer_d = timer_q - 1'b1;
        walk_d  = '0;
        if (timer_q <= 1) eng_d = ENG_BUF_APPL;
      end
      ENG_BUF_APPL: begin
        mem_we = 1'b1;
        mem_wi = buf_idx_q[walk_q[BUF_AW-1:0]];
        mem_wd = mem_q[buf_idx_q[walk_q[BUF_AW-1:0]]] & buf_data_q[walk_q[BUF_AW-1:0]];
        walk_d = walk_q + 1'b1;
        if (walk_q[BUF_AW-1:0] == cnt_q) eng_d = ENG_IDLE;
      end
      ENG_PREPROG: begin
        mem_we  = in_region;
        mem_wi  = walk_q;
        mem_wd  = PREPROG_WORD;
        walk_d  = walk_q + 1'b1;
        timer_d = TIMER_W'(ERASE_CYCLES);
        if (walk_last) eng_d = ENG_ERS_WAIT;
      end
      ENG_ERS_WAIT: begin
        timer_d = timer_q - 1'b1;
        walk_d  = '0;
        if (timer_q <= 1) eng_d = ENG_ERASE;
      end
      ENG_ERASE: begin
        mem_we = in_region;
        mem_wi = walk_q;
        mem_wd = ERASED_WORD;
        walk_d = walk_q + 1'b1;
        if (walk_last) eng_d = ENG_IDLE;
      end
      ENG_TOGGLE: begin
        timer_d = timer_q - 1'b1;
        if (timer_q <= 1) begin
          eng_d = ENG_IDLE;
          if (prot_op_q) prot_d[sect_of(tgt_q)] = 1'b1;
        end
      end
    endcase

    if (link.rd_en) begin
      if (eng_q != ENG_IDLE && bank_hit) begin
        // Burst access to busy bank unanswered
        if (!link.rd_burst) begin
          rvalid_d = 1'b1;
          rdata_d  = status_word;
          tog_d    = ~tog_q;
        end
      end else begin
        rvalid_d = 1'b1;
        rdata_d  = mem_q[mem_idx(link.addr)];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clk_en) begin
      if (mem_we) mem_q[mem_wi] <= mem_wd;
      if (buf_we) begin
        buf_idx_q[buf_wi]  <= mem_idx(link.addr);
        buf_data_q[buf_wi] <= link.wdata;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cmd_q     <= CMD_IDLE;
      eng_q     <= ENG_IDLE;
      tgt_q     <= '0;
      val_q     <= '0;
      timer_q   <= '0;
      walk_q    <= '0;
      chip_q    <= 1'b0;
      prot_op_q <= 1'b0;
      tog_q     <= 1'b0;
      cnt_q     <= '0;
      fill_q    <= '0;
      prot_q    <= '0;
      rdata_q   <= '0;
      rvalid_q  <= 1'b0;
    end else if (clk_en) begin
      cmd_q     <= cmd_d;
      eng_q     <= eng_d;
      tgt_q     <= tgt_d;
      val_q     <= val_d;
      timer_q   <= timer_d;
      walk_q    <= walk_d;
      chip_q    <= chip_d;
      prot_op_q <= prot_op_d;
      tog_q     <= tog_d;
      cnt_q     <= cnt_d;
      fill_q    <= fill_d;
      prot_q    <= prot_d;
      rdata_q   <= rdata_d;
      rvalid_q  <= rvalid_d;
    end
  end

  assign link.rdata  = rdata_q;
  assign link.rvalid = rvalid_q;
  assign busy        = (eng_q != ENG_IDLE);
  assign busy_bank   = tgt_q[ADDR_W-1 -: BANK_W];
  assign protect_map = prot_q;
endmodule : flash_device_end

/* File: shared/flash_seq_pkg.sv */
// Purpose: Shared constants and types for the flash command link.
// Assumes: 100 MHz ref_clk; word wide data bus.
// Notes:   Array geometry is a scaled model; bus address width is full size.
package flash_seq_pkg;
  localparam int DATA_W    = 16;
  localparam int ADDR_W    = 22;
  localparam int UNLOCK_W  = 16;
  localparam int BANK_W    = 2;
  localparam int SECT_W    = 2;
  localparam int LO_W      = 6;
  localparam int HI_W      = BANK_W + SECT_W;
  localparam int MEM_AW    = HI_W + LO_W;
  localparam int NUM_SECT  = 1 << HI_W;
  localparam int BUF_WORDS = 32;
  localparam int BUF_AW    = 5;
  localparam int TIMER_W   = 32;

  localparam logic [UNLOCK_W-1:0] UNLOCK_A1 = 16'h0555;
  localparam logic [UNLOCK_W-1:0] UNLOCK_A2 = 16'h02aa;
  localparam logic [DATA_W-1:0] UNLOCK_D1       = 16'h00aa;
  localparam logic [DATA_W-1:0] UNLOCK_D2       = 16'h0055;
  localparam logic [DATA_W-1:0] CMD_PROG        = 16'h00a0;
  localparam logic [DATA_W-1:0] CMD_BUF_LOAD    = 16'h0025;
  localparam logic [DATA_W-1:0] CMD_BUF_CONFIRM = 16'h0029;
  localparam logic [DATA_W-1:0] CMD_ERASE_SETUP = 16'h0080;
  localparam logic [DATA_W-1:0] CMD_SECT_ERASE  = 16'h0030;
  localparam logic [DATA_W-1:0] CMD_CHIP_ERASE  = 16'h0010;
  localparam logic [DATA_W-1:0] CMD_PROTECT     = 16'h0060;
  localparam logic [DATA_W-1:0] ERASED_WORD     = 16'hffff;
  localparam logic [DATA_W-1:0] PREPROG_WORD    = 16'h0000;

  localparam int POLL_BIT    = 7;
  localparam int TOGGLE_BIT  = 6;
  localparam int TOGGLE2_BIT = 2;

  localparam int CLK_MHZ        = 100;
  localparam int TOGGLE_PROT_US = 20;
  localparam int PROG_US        = 170;
  localparam int BUF_PROG_US    = 450;
  localparam int ERASE_US       = 800000;
  localparam logic [TIMER_W-1:0] TOGGLE_PROT_CYC = TIMER_W'(TOGGLE_PROT_US * CLK_MHZ);

  typedef enum logic [2:0] {
    OP_READ       = 3'h0,
    OP_PROG2      = 3'h1,
    OP_PROG4      = 3'h2,
    OP_BUF        = 3'h3,
    OP_SECT_ERASE = 3'h4,
    OP_CHIP_ERASE = 3'h5,
    OP_PROTECT    = 3'h6
  } host_op_type;
endpackage : flash_seq_pkg

/* File: shared/flash_link_if.sv */
// Purpose: Bus cycles between host controller and flash device.
// Assumes: Both ends on ref_clk; one write or read cycle per clock.
// Notes:   rvalid answers a read one cycle after rd_en.
`timescale 1ns/100ps
interface flash_link_if (input wire logic ref_clk);
  import flash_seq_pkg::*;
  logic                wr_en;
  logic                rd_en;
  logic                rd_burst;
  logic [ADDR_W-1:0]   addr;
  logic [DATA_W-1:0]   wdata;
  logic [DATA_W-1:0]   rdata;
  logic                rvalid;

  modport device (input wr_en, rd_en, rd_burst, addr, wdata, output rdata, rvalid);
  modport host   (output wr_en, rd_en, rd_burst, addr, wdata, input rdata, rvalid);
endinterface : flash_link_if

/* File: rtl/flash_host_end.sv */
// Purpose: Host controller issuing command cycles and polling completion.
// Assumes: Device answers reads one cycle later on rvalid.
// Notes:   One operation at a time; buffer words come from word stream.
`timescale 1ns/100ps
module flash_host_end
  import flash_seq_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          reset,
  input  wire logic          clk_en,
  flash_link_if.host         link,
  input  wire logic          op_valid,
  output logic               op_ready,
  input  wire host_op_type   op_kind,
  input  wire logic [ADDR_W-1:0] op_addr,
  input  wire logic [DATA_W-1:0] op_data,
  input  wire logic [BUF_AW-1:0] op_count,
  input  wire logic          word_valid,
  output logic               word_ready,
  input  wire logic [DATA_W-1:0] word_data,
  output logic               done,
  output logic [DATA_W-1:0]  done_data
);
  typedef enum logic [2:0] {
    H_IDLE  = 3'h0,
    H_CMD   = 3'h1,
    H_WORDS = 3'h2,
    H_CONF  = 3'h3,
    H_RD1   = 3'h4,
    H_RD2   = 3'h5,
    H_RDATA = 3'h6
  } host_state_type;

  host_state_type     st_q, st_d;
  host_op_type        kind_q, kind_d;
  logic [ADDR_W-1:0]  addr_q, addr_d;
  logic [DATA_W-1:0]  data_q, data_d, first_q, first_d, done_data_d;
  logic [BUF_AW-1:0]  cnt_q, cnt_d, wi_q, wi_d;
  logic [2:0]         step_q, step_d;
  logic               pend_q, pend_d, done_d;
  logic [ADDR_W-1:0]  s_addr;
  logic [DATA_W-1:0]  s_data;
  logic               s_last;

  logic [ADDR_W-1:0]  ul1_addr, ul2_addr;

  // Upper bits follow the target; device must ignore them
  assign ul1_addr = {addr_q[ADDR_W-1:UNLOCK_W], UNLOCK_A1};
  assign ul2_addr = {addr_q[ADDR_W-1:UNLOCK_W], UNLOCK_A2};

  always_comb begin
    s_addr = ul1_addr;
    s_data = UNLOCK_D1;
    s_last = 1'b0;
    if (step_q == 3'h1) begin
      s_addr = ul2_addr;
      s_data = UNLOCK_D2;
    end
    unique case (kind_q)
      OP_PROG2: begin
        s_addr = (step_q == 3'h0) ? addr_q : addr_q;
        s_data = (step_q == 3'h0) ? CMD_PROG : data_q;
        s_last = (step_q == 3'h1);
      end
      OP_PROG4: begin
        if (step_q == 3'h2) s_data = CMD_PROG;
        if (step_q == 3'h3) begin
          s_addr = addr_q;
          s_data = data_q;
          s_last = 1'b1;
        end
      end
      OP_BUF: begin
        if (step_q == 3'h2) begin
          s_addr = addr_q;
          s_data = CMD_BUF_LOAD;
        end
        if (step_q == 3'h3) begin
          s_addr = addr_q;
          s_data = DATA_W'(cnt_q);
          s_last = 1'b1;
        end
      end
      OP_SECT_ERASE, OP_CHIP_ERASE: begin
        if (step_q == 3'h2) s_data = CMD_ERASE_SETUP;
        if (step_q == 3'h4) begin
          s_addr = ul2_addr;
          s_data = UNLOCK_D2;
        end
        if (step_q == 3'h5) begin
          s_addr = (kind_q == OP_SECT_ERASE) ? addr_q : ul1_addr;
          s_data = (kind_q == OP_SECT_ERASE) ? CMD_SECT_ERASE : CMD_CHIP_ERASE;
          s_last = 1'b1;
        end
      end
      OP_PROTECT: begin
        if (step_q == 3'h2) begin
          s_addr = addr_q;
          s_data = CMD_PROTECT;
          s_last = 1'b1;
        end
      end
      default: s_last = 1'b1;
    endcase
  end

  always_comb begin
    st_d        = st_q;
    kind_d      = kind_q;
    addr_d      = addr_q;
    data_d      = data_q;
    first_d     = first_q;
    cnt_d       = cnt_q;
    wi_d        = wi_q;
    step_d      = step_q;
    pend_d      = pend_q;
    done_d      = 1'b0;
    done_data_d = done_data;
    link.wr_en    = 1'b0;
    link.rd_en    = 1'b0;
    link.rd_burst = 1'b0;
    link.addr     = addr_q;
    link.wdata    = '0;
    op_ready      = (st_q == H_IDLE);
    word_ready    = (st_q == H_WORDS);
    unique case (st_q)
      H_IDLE: begin
        if (op_valid) begin
          kind_d = op_kind;
          addr_d = op_addr;
          data_d = op_data;
          cnt_d  = op_count;
          step_d = '0;
          wi_d   = '0;
          pend_d = 1'b0;
          st_d   = (op_kind == OP_READ) ? H_RDATA : H_CMD;
        end
      end
      H_CMD: begin
        link.wr_en = 1'b1;
        link.addr  = s_addr;
        link.wdata = s_data;
        step_d     = step_q + 1'b1;
        if (s_last) st_d = (kind_q == OP_BUF) ? H_WORDS : H_RD1;
      end
      H_WORDS: begin
        link.addr = addr_q + ADDR_W'(wi_q);
        if (word_valid) begin
          link.wr_en = 1'b1;
          link.wdata = word_data;
          wi_d       = wi_q + 1'b1;
          if (wi_q == cnt_q) st_d = H_CONF;
        end
      end
      H_CONF: begin
        link.wr_en = 1'b1;
        link.wdata = CMD_BUF_CONFIRM;
        st_d       = H_RD1;
      end
      H_RD1, H_RD2, H_RDATA: begin
        link.rd_en = !pend_q;
        pend_d     = 1'b1;
        if (link.rvalid) begin
          pend_d = 1'b0;
          if (st_q == H_RD1) begin
            first_d = link.rdata;
            st_d    = H_RD2;
          end else if (st_q == H_RDATA
                       || link.rdata[TOGGLE_BIT] == first_q[TOGGLE_BIT]) begin
            done_d      = 1'b1;
            done_data_d = link.rdata;
            st_d        = H_IDLE;
          end else begin
            st_d = H_RD1;
          end
        end
      end
      default: st_d = H_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_q      <= H_IDLE;
      kind_q    <= OP_READ;
      addr_q    <= '0;
      data_q    <= '0;
      first_q   <= '0;
      cnt_q     <= '0;
      wi_q      <= '0;
      step_q    <= '0;
      pend_q    <= 1'b0;
      done      <= 1'b0;
      done_data <= '0;
    end else if (clk_en) begin
      st_q      <= st_d;
      kind_q    <= kind_d;
      addr_q    <= addr_d;
      data_q    <= data_d;
      first_q   <= first_d;
      cnt_q     <= cnt_d;
      wi_q      <= wi_d;
      step_q    <= step_d;
      pend_q    <= pend_d;
      done      <= done_d;
      done_data <= done_data_d;
    end
  end
endmodule : flash_host_end

/* File: tb/flash_link_props.sv */
// Purpose: Link checks between the host and device ends.
// Assumes: One clock domain; reset synchronous, active high.
// Notes:   Watches interface signals only, so no busy-side checks here.
`timescale 1ns/100ps
module flash_link_props
  import flash_seq_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              reset,
  input wire logic              wr_en,
  input wire logic              rd_en,
  input wire logic              rd_burst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic              rvalid
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic [UNLOCK_W-1:0] lo_addr;
  assign lo_addr = addr[UNLOCK_W-1:0];

  property p_read_answer; rd_en |=> rvalid; endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  property p_no_stray; !rd_en |=> !rvalid; endproperty
  a_no_stray: assert property (p_no_stray) else $error("answer without read");
  property p_async_only; rd_en |-> !rd_burst; endproperty
  a_async_only: assert property (p_async_only) else $error("burst read issued");
  property p_rdata_holds; !rvalid && !$past(reset) |-> $stable(rdata); endproperty
  a_rdata_holds: assert property (p_rdata_holds) else $error("read data moved");
  property p_unlock_pair;
    (wr_en && wdata == UNLOCK_D1) ##1 (wr_en && wdata == UNLOCK_D2)
      |-> lo_addr == UNLOCK_A2 && $past(lo_addr) == UNLOCK_A1;
  endproperty
  a_unlock_pair: assert property (p_unlock_pair) else $error("unlock address wrong");
  property p_prog_data; wr_en && wdata == CMD_PROG |=> wr_en && !rd_en; endproperty
  a_prog_data: assert property (p_prog_data) else $error("program data missing");
  property p_reset_quiet; $fell(reset) |-> !rvalid [*2]; endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("answer after reset");
  property p_read_spacing; rd_en |=> !rd_en; endproperty
  a_read_spacing: assert property (p_read_spacing) else $error("reads too close");

  c_prog: cover property (wr_en && wdata == CMD_PROG);
  c_erase: cover property (wr_en && wdata == CMD_ERASE_SETUP);
  c_poll: cover property (rd_en ##2 rd_en);
endmodule : flash_link_props

/* File: tb/flash_program_erase_status_tb.sv */
// Purpose: Host end drives device end; bench checks results and polls.
// Assumes: Shortened program, buffer and erase counts.
// Notes:   Other-bank reads need a second host; not reachable here.
`timescale 1ns/100ps
module flash_program_erase_status_tb;
  import flash_seq_pkg::*;
  logic ref_clk, reset, clk_en, op_valid, word_valid, busy, watch, rd_stat_q;
  logic op_ready, word_ready, done;
  host_op_type op_kind;
  logic [ADDR_W-1:0] op_addr;
  logic [DATA_W-1:0] op_data, word_data, done_data, exp_d, prev_stat;
  logic [BUF_AW-1:0] op_count;
  logic [BANK_W-1:0] busy_bank;
  logic [NUM_SECT-1:0] protect_map;
  int error_cnt, comparisons, stat_n, cyc;

  flash_link_if link (.ref_clk(ref_clk));
  flash_host_end i_flash_host_end (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
    .link(link), .op_valid(op_valid), .op_ready(op_ready), .op_kind(op_kind),
    .op_addr(op_addr), .op_data(op_data), .op_count(op_count), .word_valid(word_valid),
    .word_ready(word_ready), .word_data(word_data), .done(done), .done_data(done_data));
  flash_device_end #(.PROG_CYCLES(5), .BUF_CYCLES(8), .ERASE_CYCLES(10)) i_flash_device_end (
    .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .link(link), .busy(busy),
    .busy_bank(busy_bank), .protect_map(protect_map));
  flash_link_props i_flash_link_props (.ref_clk(ref_clk), .reset(reset), .wr_en(link.wr_en),
    .rd_en(link.rd_en), .rd_burst(link.rd_burst), .addr(link.addr), .wdata(link.wdata),
    .rdata(link.rdata), .rvalid(link.rvalid));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    comparisons++;
    if (exp !== got) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Status answers of the busy bank, seen on the link
  always @(posedge ref_clk) begin
    if (watch && rd_stat_q && link.rvalid) begin
      chk("poll_bit", {15'h0000, ~exp_d[POLL_BIT]}, {15'h0000, link.rdata[POLL_BIT]});
      if (stat_n > 0)
        chk("toggle", {15'h0000, ~prev_stat[TOGGLE_BIT]}, {15'h0000, link.rdata[TOGGLE_BIT]});
      prev_stat = link.rdata;
      stat_n++;
    end
    rd_stat_q <= link.rd_en && busy;
  end

  task automatic do_op(input host_op_type k, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, input logic [BUF_AW-1:0] n);
    int i;
    int wi;
    wi = 0;
    cyc = 0;
    op_kind <= k; op_addr <= a; op_data <= d; op_count <= n;
    op_valid <= 1'b1;
    word_data <= 16'h0300;
    word_valid <= (k == OP_BUF);
    @(posedge ref_clk);
    for (i = 0; i < 50 && !op_ready; i++) @(posedge ref_clk);
    op_valid <= 1'b0;
    if (!op_ready) begin
      error_cnt++;
      $display("[FAIL] op_ready expected 1 seen %b", op_ready);
      close_out();
    end
    // Bound covers erase walks plus the protected toggle window
    for (i = 0; i < 20000 && done !== 1'b1; i++) begin
      @(posedge ref_clk);
      if (word_valid && word_ready) begin
        wi++;
        word_data <= 16'h0300 + DATA_W'(wi);
        // Drop valid with the last word, not at the next op's start
        if (wi > int'(n)) word_valid <= 1'b0;
      end
      cyc++;
    end
    if (done !== 1'b1) begin
      error_cnt++;
      $display("[FAIL] op done expected 1 seen %b", done);
      close_out();
    end
  endtask : do_op

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    do_op(OP_READ, a, 16'h0000, 5'h00);
    chk("read", exp, done_data);
  endtask : rd

  task automatic t_chip_erase;
    do_op(OP_CHIP_ERASE, 22'h000000, 16'h0000, 5'h00);
    rd(22'h000005, ERASED_WORD);
    rd(22'h100007, ERASED_WORD);
    $display("test chip erase done");
  endtask : t_chip_erase

  task automatic t_program;
    exp_d = 16'h1234;
    stat_n = 0;
    watch = 1'b1;
    do_op(OP_PROG4, 22'h000005, 16'h1234, 5'h00);
    watch = 1'b0;
    chk("status_reads", 16'h0001, {15'h0000, stat_n >= 2});
    rd(22'h000005, 16'h1234);
    rd(22'h000005, 16'h1234);
    do_op(OP_PROG2, 22'h100007, 16'h5678, 5'h00);
    rd(22'h100007, 16'h5678);
    $display("test program done");
  endtask : t_program

  task automatic t_buffer;
    do_op(OP_BUF, 22'h040000, 16'h0000, 5'h1f);
    rd(22'h040000, 16'h0300);
    rd(22'h04001f, 16'h031f);
    $display("test buffer done");
  endtask : t_buffer

  task automatic t_sector_erase;
    do_op(OP_SECT_ERASE, 22'h000000, 16'h0000, 5'h00);
    rd(22'h000005, ERASED_WORD);
    rd(22'h100007, 16'h5678);
    $display("test sector erase done");
  endtask : t_sector_erase

  task automatic t_protect;
    do_op(OP_PROTECT, 22'h200000, 16'h0000, 5'h00);
    chk("protect_time", 16'h0001, {15'h0000, cyc >= int'(TOGGLE_PROT_CYC)});
    chk("protect_map", 16'h0001, {15'h0000, protect_map[8]});
    do_op(OP_PROG2, 22'h200003, 16'h1111, 5'h00);
    chk("refuse_time", 16'h0001, {15'h0000, cyc >= int'(TOGGLE_PROT_CYC)});
    rd(22'h200003, ERASED_WORD);
    $display("test protect done");
  endtask : t_protect

  initial begin
    reset = 1'b1; clk_en = 1'b1; op_valid = 1'b0; word_valid = 1'b0; watch = 1'b0;
    rd_stat_q = 1'b0; op_kind = OP_READ; op_addr = '0; op_data = '0; op_count = '0;
    word_data = '0; exp_d = '0; prev_stat = '0;
    error_cnt = 0; comparisons = 0; stat_n = 0;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    t_chip_erase();
    t_program();
    t_buffer();
    t_sector_erase();
    t_protect();
    close_out();
  end
endmodule : flash_program_erase_status_tb
